// ### rtl/ufc_map.vh
`ifndef UFC_MAP_VH
`define UFC_MAP_VH

// Register byte offsets
`define UFC_OFS_CTRL      8'h00
`define UFC_OFS_STATUS    8'h04
`define UFC_OFS_IRQ_STAT  8'h08
`define UFC_OFS_IRQ_MASK  8'h0C
`define UFC_OFS_TX_DATA   8'h10
`define UFC_OFS_RX_DATA   8'h14

// fifo_control fields
`define UFC_CTL_FIFO_EN   0
`define UFC_CTL_RX_FLUSH  1
`define UFC_CTL_TX_FLUSH  2
`define UFC_CTL_DMA_MODE  3
`define UFC_CTL_TX_SEL_LO 4
`define UFC_CTL_TX_SEL_HI 5
`define UFC_CTL_RX_SEL_LO 6
`define UFC_CTL_RX_SEL_HI 7

// Interrupt status and mask bits
`define UFC_IRQ_RX        0
`define UFC_IRQ_TX        1

// Reset values
`define UFC_RST_SEL       2'h0
`define UFC_RST_MASK      2'h0

// Receive thresholds by rx_threshold_sel
`define UFC_RX_TRIG_0     6'h08
`define UFC_RX_TRIG_1     6'h10
`define UFC_RX_TRIG_2     6'h18
`define UFC_RX_TRIG_3     6'h1C

// Transmit thresholds by tx_threshold_sel
`define UFC_TX_TRIG_0     6'h10
`define UFC_TX_TRIG_1     6'h08
`define UFC_TX_TRIG_2     6'h18
`define UFC_TX_TRIG_3     6'h1E

`endif

// ### rtl/ufc_top.v
// Function
// - Mode 0: transmit request low while transmit FIFO or holding register empty.
// - Mode 0: receive request low when a character is loaded into receive holding.
// - Mode 1: transmit interrupt when transmit occupancy falls below its trigger.
// - Mode 1: receive interrupt at trigger level; keep accepting until full.
// - Mode 1: receive request stays low while fill is above trigger.
// - Control bits 7-6 select receive threshold; interrupt when count equals it.
// - Control bits 5-4 select transmit threshold, default 16; interrupt below it.
// - Control bit 3 selects DMA mode; reset gives mode 0.
// - Mode 0: transmit request low while empty, high after first load.
// - Mode 0: receive request low while any character held, high when none.
// - Mode 1: transmit request high when full, low when below trigger.
// - Mode 1: receive request low on trigger or timeout, high only when empty.
// - Control bit 2 flushes transmit FIFO and counter; self-clearing, zero no effect.
// - Control bit 0 enables FIFOs; other bits programmed only when it is one.
// - Receive threshold codes 00..11 give 8, 16, 24, 28 bytes.
// - Transmit threshold codes 00..11 give 16, 8, 24, 30 bytes.
// - Control bit 1 flushes receive FIFO and counter; self-clearing.
//
// Chosen here: register access over AHB-Lite and the address map.
`timescale 1ns/1ps
`include "ufc_map.vh"
`default_nettype none

module ufc_top #(
    parameter DEPTH = 32,
    parameter AW    = 5
) (
    input  wire        clk_in,          // Device clock, 25 MHz
    input  wire        rst_in,          // Synchronous reset, active high
    input  wire        hsel_in,         // AHB slave select
    input  wire [31:0] haddr_in,        // AHB address
    input  wire [1:0]  htrans_in,       // AHB transfer type
    input  wire        hwrite_in,       // AHB write
    input  wire [2:0]  hsize_in,        // AHB size, word only
    input  wire [31:0] hwdata_in,       // AHB write data
    input  wire        hready_in,       // AHB bus ready
    output reg  [31:0] hrdata_out,      // AHB read data
    output reg         hreadyout_out,   // AHB slave ready
    output reg         hresp_out,       // AHB response, always OKAY
    input  wire        rx_push_in,      // Receiver delivers a character
    input  wire [7:0]  rx_data_in,      // Received character
    input  wire        rx_timeout_in,   // Receive time-out pulse
    input  wire        tx_pop_in,       // Transmitter takes a character
    output reg  [7:0]  tx_data_out,     // Character taken by last pop
    output reg         tx_avail_out,    // Transmit FIFO holds data
    output reg         tx_dma_request_n_out, // Transmit ready, active low
    output reg         rx_dma_request_n_out, // Receive ready, active low
    output reg         irq_out          // Level interrupt
);

    reg  [7:0]  tx_mem_ff [0:DEPTH-1];
    reg  [7:0]  rx_mem_ff [0:DEPTH-1];
    reg  [AW-1:0] tx_wp_ff;
    reg  [AW-1:0] tx_rp_ff;
    reg  [AW-1:0] rx_wp_ff;
    reg  [AW-1:0] rx_rp_ff;
    reg  [AW:0] tx_cnt_ff;
    reg  [AW:0] rx_cnt_ff;
    reg         fifo_en_ff;
    reg         dma_mode_ff;
    reg  [1:0]  rx_sel_ff;
    reg  [1:0]  tx_sel_ff;
    reg  [1:0]  irq_stat_ff;
    reg  [1:0]  irq_mask_ff;
    reg         dp_wr_ff;
    reg  [7:0]  dp_addr_ff;

    reg  [AW:0] nxt_tx_cnt;
    reg  [AW:0] nxt_rx_cnt;
    reg  [1:0]  nxt_irq_stat;
    reg  [31:0] nxt_rdata;
    reg         nxt_tx_req_n;
    reg         nxt_rx_req_n;
    reg         nxt_fifo_en;
    reg         nxt_dma_mode;
    reg  [1:0]  nxt_rx_sel;
    reg  [1:0]  nxt_tx_sel;
    reg         tx_flush;
    reg         rx_flush;
    reg  [1:0]  irq_evt;
    reg  [5:0]  rx_trig;
    reg  [5:0]  tx_trig;

    wire        addr_ok  = hsel_in & hready_in & htrans_in[1];
    wire        wr_ctl   = dp_wr_ff & (dp_addr_ff == `UFC_OFS_CTRL);
    wire        wr_txd   = dp_wr_ff & (dp_addr_ff == `UFC_OFS_TX_DATA);
    wire        wr_clr   = dp_wr_ff & (dp_addr_ff == `UFC_OFS_IRQ_STAT);
    wire        wr_mask  = dp_wr_ff & (dp_addr_ff == `UFC_OFS_IRQ_MASK);
    wire        rd_rxd   = addr_ok & ~hwrite_in & (haddr_in[7:0] == `UFC_OFS_RX_DATA);
    // Disabled FIFOs shrink to a single holding register
    wire [AW:0] cap      = fifo_en_ff ? DEPTH[AW:0] : {{AW{1'b0}}, 1'b1};
    wire        tx_push  = wr_txd & (tx_cnt_ff < cap);
    wire        tx_pop   = tx_pop_in & (tx_cnt_ff != {(AW+1){1'b0}});
    wire        rx_push  = rx_push_in & (rx_cnt_ff < cap);
    wire        rx_pop   = rd_rxd & (rx_cnt_ff != {(AW+1){1'b0}});
    wire        block_md = fifo_en_ff & dma_mode_ff;

    always @* begin
        case (rx_sel_ff)
            2'h0: rx_trig = `UFC_RX_TRIG_0;
            2'h1: rx_trig = `UFC_RX_TRIG_1;
            2'h2: rx_trig = `UFC_RX_TRIG_2;
            2'h3: rx_trig = `UFC_RX_TRIG_3;
            default: rx_trig = `UFC_RX_TRIG_0;
        endcase
        case (tx_sel_ff)
            2'h0: tx_trig = `UFC_TX_TRIG_0;
            2'h1: tx_trig = `UFC_TX_TRIG_1;
            2'h2: tx_trig = `UFC_TX_TRIG_2;
            2'h3: tx_trig = `UFC_TX_TRIG_3;
            default: tx_trig = `UFC_TX_TRIG_0;
        endcase
    end

    always @* begin
        nxt_fifo_en  = fifo_en_ff;
        nxt_dma_mode = dma_mode_ff;
        nxt_rx_sel   = rx_sel_ff;
        nxt_tx_sel   = tx_sel_ff;
        tx_flush     = 1'b0;
        rx_flush     = 1'b0;
        if (wr_ctl) begin
            // Other bits only land alongside the enable bit
            if (hwdata_in[`UFC_CTL_FIFO_EN]) begin
                nxt_fifo_en  = 1'b1;
                nxt_dma_mode = hwdata_in[`UFC_CTL_DMA_MODE];
                nxt_rx_sel   = hwdata_in[`UFC_CTL_RX_SEL_HI:`UFC_CTL_RX_SEL_LO];
                nxt_tx_sel   = hwdata_in[`UFC_CTL_TX_SEL_HI:`UFC_CTL_TX_SEL_LO];
                tx_flush     = hwdata_in[`UFC_CTL_TX_FLUSH];
                rx_flush     = hwdata_in[`UFC_CTL_RX_FLUSH];
            end else begin
                nxt_fifo_en  = 1'b0;
            end
            // Capacity changes, so stale contents are dropped
            if (nxt_fifo_en != fifo_en_ff) begin
                tx_flush = 1'b1;
                rx_flush = 1'b1;
            end
        end
    end

    always @* begin
        if (tx_flush) begin
            nxt_tx_cnt = {(AW+1){1'b0}};
        end else begin
            nxt_tx_cnt = tx_cnt_ff + {{AW{1'b0}}, tx_push} - {{AW{1'b0}}, tx_pop};
        end
        if (rx_flush) begin
            nxt_rx_cnt = {(AW+1){1'b0}};
        end else begin
            nxt_rx_cnt = rx_cnt_ff + {{AW{1'b0}}, rx_push} - {{AW{1'b0}}, rx_pop};
        end
    end

    always @* begin
        irq_evt = 2'h0;
        if (fifo_en_ff) begin
            irq_evt[`UFC_IRQ_RX] = rx_push & (nxt_rx_cnt == rx_trig) & ~rx_flush;
            irq_evt[`UFC_IRQ_TX] = (tx_cnt_ff >= tx_trig) & (nxt_tx_cnt < tx_trig);
        end else begin
            irq_evt[`UFC_IRQ_RX] = rx_push & ~rx_flush;
            irq_evt[`UFC_IRQ_TX] = (tx_cnt_ff != {(AW+1){1'b0}})
                                 & (nxt_tx_cnt == {(AW+1){1'b0}});
        end
        // New events win over a same-cycle clear
        nxt_irq_stat = irq_stat_ff;
        if (wr_clr) begin
            nxt_irq_stat = irq_stat_ff & ~hwdata_in[1:0];
        end
        nxt_irq_stat = nxt_irq_stat | irq_evt;
    end

    always @* begin
        nxt_tx_req_n = tx_dma_request_n_out;
        nxt_rx_req_n = rx_dma_request_n_out;
        if (block_md) begin
            // Hysteresis between the two edges keeps the block request stable
            if (nxt_tx_cnt == DEPTH[AW:0]) begin
                nxt_tx_req_n = 1'b1;
            end else if (nxt_tx_cnt < tx_trig) begin
                nxt_tx_req_n = 1'b0;
            end
            if (nxt_rx_cnt == {(AW+1){1'b0}}) begin
                nxt_rx_req_n = 1'b1;
            end else if ((nxt_rx_cnt >= rx_trig) | rx_timeout_in) begin
                nxt_rx_req_n = 1'b0;
            end
        end else begin
            nxt_tx_req_n = (nxt_tx_cnt != {(AW+1){1'b0}});
            nxt_rx_req_n = (nxt_rx_cnt == {(AW+1){1'b0}});
        end
    end

    always @* begin
        nxt_rdata = 32'h0000_0000;
        case (haddr_in[7:0])
            `UFC_OFS_STATUS: begin
                nxt_rdata[5:0]   = tx_cnt_ff;
                nxt_rdata[13:8]  = rx_cnt_ff;
                nxt_rdata[16]    = fifo_en_ff;
                nxt_rdata[17]    = dma_mode_ff;
                nxt_rdata[19:18] = rx_sel_ff;
                nxt_rdata[21:20] = tx_sel_ff;
                nxt_rdata[24]    = tx_dma_request_n_out;
                nxt_rdata[25]    = rx_dma_request_n_out;
            end
            `UFC_OFS_IRQ_STAT: nxt_rdata[1:0] = irq_stat_ff;
            `UFC_OFS_IRQ_MASK: nxt_rdata[1:0] = irq_mask_ff;
            `UFC_OFS_RX_DATA: begin
                if (rx_cnt_ff != {(AW+1){1'b0}}) begin
                    nxt_rdata[7:0] = rx_mem_ff[rx_rp_ff];
                end
            end
            default: nxt_rdata = 32'h0000_0000;
        endcase
    end

    always @(posedge clk_in) begin
        if (tx_push) begin
            tx_mem_ff[tx_wp_ff] <= hwdata_in[7:0];
        end
        if (rx_push) begin
            rx_mem_ff[rx_wp_ff] <= rx_data_in;
        end
    end

    always @(posedge clk_in) begin
        if (rst_in) begin
            tx_wp_ff             <= {AW{1'b0}};
            tx_rp_ff             <= {AW{1'b0}};
            rx_wp_ff             <= {AW{1'b0}};
            rx_rp_ff             <= {AW{1'b0}};
            tx_cnt_ff            <= {(AW+1){1'b0}};
            rx_cnt_ff            <= {(AW+1){1'b0}};
            fifo_en_ff           <= 1'b0;
            dma_mode_ff          <= 1'b0;
            rx_sel_ff            <= `UFC_RST_SEL;
            tx_sel_ff            <= `UFC_RST_SEL;
            irq_stat_ff          <= 2'h0;
            irq_mask_ff          <= `UFC_RST_MASK;
            dp_wr_ff             <= 1'b0;
            dp_addr_ff           <= 8'h00;
            hrdata_out           <= 32'h0000_0000;
            hreadyout_out        <= 1'b1;
            hresp_out            <= 1'b0;
            tx_data_out          <= 8'h00;
            tx_avail_out         <= 1'b0;
            tx_dma_request_n_out <= 1'b0;
            rx_dma_request_n_out <= 1'b1;
            irq_out              <= 1'b0;
        end else begin
            // Wrap at cap: single-slot mode keeps both pointers at zero
            if (tx_flush) begin
                tx_wp_ff <= {AW{1'b0}};
                tx_rp_ff <= {AW{1'b0}};
            end else begin
                if (tx_push) begin
                    tx_wp_ff <= fifo_en_ff ? tx_wp_ff + {{(AW-1){1'b0}}, 1'b1} : {AW{1'b0}};
                end
                if (tx_pop) begin
                    tx_rp_ff <= fifo_en_ff ? tx_rp_ff + {{(AW-1){1'b0}}, 1'b1} : {AW{1'b0}};
                end
            end
            if (rx_flush) begin
                rx_wp_ff <= {AW{1'b0}};
                rx_rp_ff <= {AW{1'b0}};
            end else begin
                if (rx_push) begin
                    rx_wp_ff <= fifo_en_ff ? rx_wp_ff + {{(AW-1){1'b0}}, 1'b1} : {AW{1'b0}};
                end
                if (rx_pop) begin
                    rx_rp_ff <= fifo_en_ff ? rx_rp_ff + {{(AW-1){1'b0}}, 1'b1} : {AW{1'b0}};
                end
            end
            tx_cnt_ff            <= nxt_tx_cnt;
            rx_cnt_ff            <= nxt_rx_cnt;
            fifo_en_ff           <= nxt_fifo_en;
            dma_mode_ff          <= nxt_dma_mode;
            rx_sel_ff            <= nxt_rx_sel;
            tx_sel_ff            <= nxt_tx_sel;
            irq_stat_ff          <= nxt_irq_stat;
            if (wr_mask) begin
                irq_mask_ff <= hwdata_in[1:0];
            end
            dp_wr_ff             <= addr_ok & hwrite_in;
            dp_addr_ff           <= haddr_in[7:0];
            if (addr_ok & ~hwrite_in) begin
                hrdata_out <= nxt_rdata;
            end
            hreadyout_out        <= 1'b1;
            hresp_out            <= 1'b0;
            if (tx_pop) begin
                tx_data_out <= tx_mem_ff[tx_rp_ff];
            end
            tx_avail_out         <= (nxt_tx_cnt != {(AW+1){1'b0}});
            tx_dma_request_n_out <= nxt_tx_req_n;
            rx_dma_request_n_out <= nxt_rx_req_n;
            irq_out              <= |(nxt_irq_stat & irq_mask_ff);
        end
    end

endmodule

`default_nettype wire

// ### tb/tb_uart_fifo_control_dma_handshake.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin miscompares++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_uart_fifo_control_dma_handshake;
    logic        clk_in = 0, rst_in = 1, hsel = 0, hwrite = 0, en = 0, md = 0;
    logic [1:0]  htrans = 2'h0, rs = 2'h0, ts = 2'h0;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, res_val, e_v, seed = 32'h9b5c_3890;
    logic        hrdy, hresp, rx_push, rx_to, tx_pop, tx_av, tx_req_n, rx_req_n, irq;
    logic [7:0]  rx_data, tx_data, b;
    logic [31:0] exp_q[$];
    logic [7:0]  rxq[$], txq[$];
    int          miscompares = 0, checks_done = 0, tc = 0, rc = 0, s;
    int          rt[4] = '{8, 16, 24, 28}, tt[4] = '{16, 8, 24, 30};
    event        res_ev;
    always #20 clk_in = ~clk_in;
    ufc_top ufc_top_inst (.clk_in(clk_in), .rst_in(rst_in), .hsel_in(hsel), .haddr_in(haddr),
        .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata),
        .hready_in(hrdy), .hrdata_out(hrdata), .hreadyout_out(hrdy), .hresp_out(hresp),
        .rx_push_in(rx_push), .rx_data_in(rx_data), .rx_timeout_in(rx_to), .tx_pop_in(tx_pop),
        .tx_data_out(tx_data), .tx_avail_out(tx_av), .tx_dma_request_n_out(tx_req_n),
        .rx_dma_request_n_out(rx_req_n), .irq_out(irq));
    ufc_line_model ufc_line_model_inst (.clk_in(clk_in), .tx_data_in(tx_data),
        .rx_push_out(rx_push), .rx_data_out(rx_data), .rx_timeout_out(rx_to),
        .tx_pop_out(tx_pop));
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [31:0] st(int t, int r, logic tn, logic rn);
        return {6'h00, rn, tn, 2'h0, ts, rs, md, en, 2'h0, r[5:0], 2'h0, t[5:0]};
    endfunction
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        do @(posedge clk_in); while (hrdy !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk_in); while (hrdy !== 1'b1);
        q = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        bus(1'b0, a, 32'h0, res_val);
        ->res_ev;
        // Let the checker take this note before another can overwrite it
        wait (exp_q.size() == 0);
    endtask
    task automatic note(input logic [31:0] e, input logic [31:0] g);
        exp_q.push_back(e);
        res_val = g;
        ->res_ev;
        wait (exp_q.size() == 0);
    endtask
    // Any enable change, or a flush bit written with enable set, empties that FIFO in the expectation too
    task automatic ctl(input logic e, m, input logic [1:0] r, t, fl);
        if (e != en || (e && fl[0])) begin rc = 0; rxq.delete(); end
        if (e != en || (e && fl[1])) begin tc = 0; txq.delete(); end
        en = e;
        if (e) begin md = m; rs = r; ts = t; end
        wr(8'h00, {24'h0, r, t, m, fl, e});
    endtask
    task automatic push();
        b = rnd();
        ufc_line_model_inst.send(b);
        if (rc < (en ? 32 : 1)) begin rc++; rxq.push_back(b); end
    endtask
    task automatic txw();
        b = rnd();
        wr(8'h10, {24'h0, b});
        if (tc < (en ? 32 : 1)) begin tc++; txq.push_back(b); end
    endtask
    task automatic pop_rx();
        rd(8'h14, {24'h0, rxq.pop_front()});
        rc--;
    endtask
    task automatic pop_tx();
        ufc_line_model_inst.take(b);
        note({24'h0, txq.pop_front()}, {24'h0, b});
        tc--;
    endtask
    always @(res_ev) begin
        e_v = exp_q.pop_front();
        `CHK(res_val, e_v)
    end
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk_in);
        miscompares++;
        give_verdict();
    end
    initial begin
        repeat (10) @(posedge clk_in);
        rst_in <= 1'b0;
        @(posedge clk_in);
        rd(8'h04, st(0, 0, 0, 1));
        rd(8'h00, 32'h0);
        rd(8'h20, 32'h0);
        wr(8'h20, 32'hffff_ffff);
        ctl(1'b0, 1'b1, 2'h3, 2'h3, 2'h3);
        rd(8'h04, st(0, 0, 0, 1));
        push();
        push();
        rd(8'h04, st(0, 1, 0, 0));
        pop_rx();
        rd(8'h04, st(0, 0, 0, 1));
        txw();
        rd(8'h04, st(1, 0, 1, 1));
        pop_tx();
        rd(8'h04, st(0, 0, 0, 1));
        rd(8'h08, 32'h3);
        note(32'h0, {31'h0, irq});
        wr(8'h0c, 32'h3);
        for (s = 0; s < 4; s++) begin
            ctl(1'b1, 1'b1, s[1:0], s[1:0], 2'h3);
            wr(8'h08, 32'h3);
            repeat (rt[s] - 1) push();
            rd(8'h04, st(0, rc, 0, 1));
            rd(8'h08, 32'h0);
            push();
            rd(8'h04, st(0, rc, 0, 0));
            rd(8'h08, 32'h1);
            note(32'h1, {31'h0, irq});
            repeat (33 - rt[s]) push();
            rd(8'h04, st(0, 32, 0, 0));
            repeat (33 - rt[s]) pop_rx();
            rd(8'h04, st(0, rc, 0, 0));
            ctl(1'b1, 1'b1, s[1:0], s[1:0], 2'h1);
            rd(8'h04, st(0, 0, 0, 1));
            push();
            rd(8'h04, st(0, 1, 0, 1));
            ufc_line_model_inst.pulse_timeout();
            rd(8'h04, st(0, 1, 0, 0));
            pop_rx();
            repeat (33) txw();
            rd(8'h04, st(32, 0, 1, 1));
            repeat (32 - tt[s]) pop_tx();
            rd(8'h04, st(tc, 0, 1, 1));
            wr(8'h08, 32'h3);
            pop_tx();
            rd(8'h04, st(tc, 0, 0, 1));
            rd(8'h08, 32'h2);
            ctl(1'b1, 1'b1, s[1:0], s[1:0], 2'h2);
            rd(8'h04, st(0, 0, 0, 1));
            txw();
            ctl(1'b1, 1'b1, s[1:0], s[1:0], 2'h0);
            rd(8'h04, st(1, 0, 0, 1));
        end
        // FIFOs on with mode 0: single-character signalling
        ctl(1'b1, 1'b0, 2'h0, 2'h0, 2'h3);
        txw();
        rd(8'h04, st(1, 0, 1, 1));
        push();
        rd(8'h04, st(1, 1, 1, 0));
        pop_rx();
        rd(8'h04, st(1, 0, 1, 1));
        give_verdict();
    end
endmodule
`default_nettype wire

// ### tb/ufc_chk_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module ufc_chk (
    input wire logic        clk_in,
    input wire logic        rst_in,
    input wire logic        hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0]  htrans_in,
    input wire logic        hwrite_in,
    input wire logic [31:0] hwdata_in,
    input wire logic        hready_in,
    input wire logic        rx_push_in,
    input wire logic        tx_avail_out,
    input wire logic        tx_dma_request_n_out,
    input wire logic        rx_dma_request_n_out,
    input wire logic        irq_out
);
    logic       dv_ff, dw_ff, m1_ff;
    logic [7:0] da_ff;
    logic [1:0] mask_ff;
    logic       take, rd_rx, wr_ctl, wr_tx;
    assign take   = hsel_in & hready_in & htrans_in[1];
    assign rd_rx  = take & !hwrite_in & (haddr_in[7:0] == 8'h14);
    assign wr_ctl = dv_ff & dw_ff & (da_ff == 8'h00);
    assign wr_tx  = dv_ff & dw_ff & (da_ff == 8'h10);
    // Shadow of mode and mask, rebuilt from the bus writes
    always_ff @(posedge clk_in) begin
        dw_ff <= hwrite_in;
        da_ff <= haddr_in[7:0];
        if (rst_in) begin
            dv_ff   <= 1'b0;
            m1_ff   <= 1'b0;
            mask_ff <= 2'h0;
        end else begin
            dv_ff <= take;
            if (wr_ctl) m1_ff <= hwdata_in[0] & hwdata_in[3];
            if (dv_ff & dw_ff & (da_ff == 8'h0c)) mask_ff <= hwdata_in[1:0];
        end
    end
    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);
    reset_req_a: assert property ($fell(rst_in) |->
        !tx_dma_request_n_out && rx_dma_request_n_out && !irq_out) else $error("bad reset");
    txreq_mode0_a: assert property (!m1_ff && !$past(m1_ff) |->
        tx_dma_request_n_out == tx_avail_out) else $error("tx request not empty flag");
    rxreq_push_a: assert property (!m1_ff && !$past(m1_ff) && $past(rx_push_in)
        && !$past(rd_rx) && !$past(wr_ctl) |-> !rx_dma_request_n_out) else $error("rx not low");
    rxreq_empty_a: assert property ($rose(rx_dma_request_n_out) |->
        $past(rd_rx) || $past(wr_ctl)) else $error("rx request released without pop");
    txavail_rise_a: assert property ($rose(tx_avail_out) |-> $past(wr_tx))
        else $error("tx data without a load");
    txflush_a: assert property (wr_ctl && hwdata_in[0] && hwdata_in[2] |=> !tx_avail_out)
        else $error("tx flush left data");
    rxflush_a: assert property (wr_ctl && hwdata_in[0] && hwdata_in[1] && !rx_push_in
        |=> rx_dma_request_n_out) else $error("rx flush left request");
    irq_mask_a: assert property (mask_ff == 2'h0 && $past(mask_ff) == 2'h0 |-> !irq_out)
        else $error("masked interrupt seen");
    cover property (m1_ff && $fell(rx_dma_request_n_out));
    cover property (m1_ff && $rose(tx_dma_request_n_out));
    cover property ($rose(irq_out));
endmodule
bind ufc_top ufc_chk ufc_chk_inst (.clk_in(clk_in), .rst_in(rst_in), .hsel_in(hsel_in),
    .haddr_in(haddr_in), .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hwdata_in(hwdata_in),
    .hready_in(hready_in), .rx_push_in(rx_push_in), .tx_avail_out(tx_avail_out),
    .tx_dma_request_n_out(tx_dma_request_n_out), .irq_out(irq_out),
    .rx_dma_request_n_out(rx_dma_request_n_out));
`default_nettype wire

// ### tb/ufc_line_model.sv
`timescale 1ns/1ps
`default_nettype none
module ufc_line_model (
    input  wire logic       clk_in,         // Clock
    input  wire logic [7:0] tx_data_in,     // Character popped
    output var  logic       rx_push_out,    // Deliver character
    output var  logic [7:0] rx_data_out,    // Delivered character
    output var  logic       rx_timeout_out, // Time-out pulse
    output var  logic       tx_pop_out      // Take character
);
    initial begin
        rx_push_out = 1'b0;
        rx_data_out = 8'h00;
        rx_timeout_out = 1'b0;
        tx_pop_out = 1'b0;
    end
    // Idle data line inverted so a stale byte never looks valid
    task automatic send(input logic [7:0] b);
        rx_push_out <= 1'b1;
        rx_data_out <= b;
        @(posedge clk_in);
        rx_push_out <= 1'b0;
        rx_data_out <= ~b;
        @(posedge clk_in);
    endtask
    task automatic pulse_timeout();
        rx_timeout_out <= 1'b1;
        @(posedge clk_in);
        rx_timeout_out <= 1'b0;
        @(posedge clk_in);
    endtask
    task automatic take(output logic [7:0] q);
        tx_pop_out <= 1'b1;
        @(posedge clk_in);
        tx_pop_out <= 1'b0;
        @(posedge clk_in);
        q = tx_data_in;
    endtask
endmodule
`default_nettype wire
